// [mscr_pkg.sv]
/*
 * Package for the metering configuration register slice: offsets, fields,
 * reset values and carrier structs.
 * Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
 */
package mscr_pkg;

    // Printed offsets are not all multiples of four: each is an index
    localparam logic [15:0] IDX_WD_RESTART   = 16'h00e8;
    localparam logic [15:0] IDX_TEST_SEL     = 16'h2000;
    localparam logic [15:0] IDX_SUM_CYCLES   = 16'h2001;
    localparam logic [15:0] IDX_WD_FLAG      = 16'h2002;
    localparam logic [15:0] IDX_REF_CTRL     = 16'h2004;
    localparam logic [15:0] IDX_RSVD_CTRL    = 16'h2005;
    localparam logic [15:0] IDX_SI_REV       = 16'h2006;
    localparam logic [15:0] IDX_SO_CTRL      = 16'h2070;
    localparam logic [15:0] IDX_SO_BEGIN     = 16'h2071;
    localparam logic [15:0] IDX_SO_END       = 16'h2072;
    localparam logic [15:0] IDX_FUSE_SEL     = 16'h20fd;
    localparam logic [15:0] IDX_FUSE_READ    = 16'h20ff;
    localparam int          ADDR_W           = 18;

    // Field positions
    localparam int BIT_WD_RESTART = 7;
    localparam int BIT_WATCHDOG_FLAG_STATUS     = 2;
    localparam int BIT_REF_OUT    = 7;
    localparam int BIT_REF_DIS    = 3;
    localparam int BIT_RDY_EN     = 1;
    localparam int BIT_RDY_POL    = 0;
    localparam int BIT_RSVD       = 7;

    // Fuse select codes
    localparam logic [7:0] FUSE_TEMP = 8'h04;
    localparam logic [7:0] FUSE_BGA  = 8'h05;
    localparam logic [7:0] FUSE_BGB  = 8'h06;

    // Revision value is arbitrary
    localparam logic [7:0] SI_REVISION = 8'h5a;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Pin synchroniser rests at the pin's idle (released) level
    localparam logic [1:0] RST_SYNC_IDLE = 2'b11;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Test selector codes
    localparam logic [3:0] TSEL_RTM   = 4'h4;
    localparam logic [3:0] TSEL_CMPLV = 4'h5;
    localparam logic [3:0] TSEL_RXD   = 4'h8;
    localparam logic [3:0] TSEL_MSYNC = 4'h9;
    localparam logic [3:0] TSEL_FAST  = 4'ha;
    localparam logic [3:0] TSEL_PCLK  = 4'hb;
    localparam logic [3:0] TSEL_RTC   = 4'hd;
    localparam logic [3:0] TSEL_CEBSY = 4'he;
    localparam logic [3:0] TSEL_XFBSY = 4'hf;

    // Digital sources for the test output
    typedef struct packed {
        logic realtime_monitor;
        logic comparator_low_voltage_term;
        logic optical_rx;
        logic mux_sync;
        logic fast_clock;
        logic processor_clock;
        logic rtc_clock;
        logic engine_busy;
        logic transfer_busy;
    } mscr_tsrc_t;

    // All register state of the block
    typedef struct packed {
        logic [7:0]  test_sel;
        logic [7:0]  sum_cycles;
        logic        watchdog_flag_status;
        logic [7:0]  ref_ctrl;
        logic [7:0]  rsvd_ctrl;
        logic [7:0]  so_ctrl;
        logic [7:0]  so_begin;
        logic [7:0]  so_end;
        logic [7:0]  fuse_sel;
        logic        wd_restart;
        logic        aw_held;
        logic [15:0] aw_idx;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  rst_sync;
    } mscr_state_t;

endpackage

// [mscr_regs.sv]
/*
 * Configuration and status register slice of a metering controller:
 * serial-output ready pin, block bounds, sum-cycle count, test selector,
 * trim fuse readout, revision, reference routing and watchdog flags.
 * Assumes an AXI4-Lite master on aclk and asynchronous pin inputs.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module mscr_regs
    import mscr_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              external_reset_n,
    input  wire logic              watchdog_overflow,
    input  wire logic              serial_out_enable,
    input  wire logic              serial_ready_strobe,
    input  wire logic              segment_drive,
    output logic                   shared_segment_pin,
    input  wire mscr_tsrc_t        test_sources,
    output logic                   test_output_pin,
    input  wire logic [2:0]        temperature_fuse,
    input  wire logic [7:0]        bandgap_fuse_a,
    input  wire logic [7:0]        bandgap_fuse_b,
    output logic                   reference_route,
    output logic                   reference_off,
    output logic [7:0]             block_begin_addr,
    output logic [7:0]             block_end_addr,
    output logic [5:0]             sum_cycle_count,
    output logic                   watchdog_restart_bit
);

    mscr_state_t s_r;
    mscr_state_t s_nxt;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] ar_idx;
    logic        ext_rst_n_s;
    logic [7:0]  fuse_value;
    logic        rdy_active;

    // Register index is the byte address over four
    assign ar_idx      = s_axi_araddr[ADDR_W-1:2];
    assign ext_rst_n_s = s_r.rst_sync[1];
    assign wr_fire     = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign rd_fire     = s_axi_arvalid && s_axi_arready;

    // Handshakes: each channel accepts once, held until response retires;
    // readies drop while frozen so that no beat is taken and then lost
    assign s_axi_awready = clk_en && !s_r.aw_held && !s_r.bvalid;
    assign s_axi_wready  = clk_en && !s_r.w_held && !s_r.bvalid;
    assign s_axi_arready = clk_en && !s_r.rvalid;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

    // Fuse readout follows the last select write
    always_comb begin
        unique case (s_r.fuse_sel)
            FUSE_TEMP: fuse_value = {5'h00, temperature_fuse};
            FUSE_BGA:  fuse_value = bandgap_fuse_a;
            FUSE_BGB:  fuse_value = bandgap_fuse_b;
            default:   fuse_value = 8'h00;
        endcase
    end

    // Pin and control outputs
    assign rdy_active = s_r.so_ctrl[BIT_RDY_EN] && serial_out_enable;
    always_comb begin
        if (rdy_active) begin
            shared_segment_pin = serial_ready_strobe ^ s_r.so_ctrl[BIT_RDY_POL];
        end else begin
            shared_segment_pin = segment_drive;
        end
    end
    assign reference_off   = s_r.ref_ctrl[BIT_REF_DIS];
    assign reference_route = s_r.ref_ctrl[BIT_REF_OUT] && !s_r.ref_ctrl[BIT_REF_DIS];
    assign block_begin_addr = s_r.so_begin;
    assign block_end_addr   = s_r.so_end;
    assign sum_cycle_count  = s_r.sum_cycles[5:0];
    assign watchdog_restart_bit = s_r.wd_restart;

    // Test output selector; analog and reserved codes read low here
    always_comb begin
        unique case (s_r.test_sel[3:0])
            TSEL_RTM:   test_output_pin = test_sources.realtime_monitor;
            TSEL_CMPLV: test_output_pin = test_sources.comparator_low_voltage_term;
            TSEL_RXD:   test_output_pin = test_sources.optical_rx;
            TSEL_MSYNC: test_output_pin = test_sources.mux_sync;
            TSEL_FAST:  test_output_pin = test_sources.fast_clock;
            TSEL_PCLK:  test_output_pin = test_sources.processor_clock;
            TSEL_RTC:   test_output_pin = test_sources.rtc_clock;
            TSEL_CEBSY: test_output_pin = test_sources.engine_busy;
            TSEL_XFBSY: test_output_pin = test_sources.transfer_busy;
            default:    test_output_pin = 1'b0;
        endcase
    end

    // Next-state logic: bus channels, register writes, flag set/clear
    always_comb begin
        logic [7:0] wb;
        logic       hit;
        logic [7:0] rb;
        wb    = 8'h00;
        hit   = 1'b0;
        rb    = 8'h00;
        s_nxt = s_r;
        s_nxt.rst_sync   = {s_r.rst_sync[0], external_reset_n};
        s_nxt.wd_restart = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_idx  = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_fire) begin
            // Only the low byte lane carries register data
            wb  = s_r.w_data[7:0];
            hit = 1'b1;
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            if (s_r.w_strb[0]) begin
                unique case (s_r.aw_idx)
                    IDX_WD_RESTART: s_nxt.wd_restart = wb[BIT_WD_RESTART];
                    IDX_TEST_SEL:   s_nxt.test_sel   = {4'h0, wb[3:0]};
                    IDX_SUM_CYCLES: s_nxt.sum_cycles = {2'b00, wb[5:0]};
                    IDX_WD_FLAG:    begin
                        if (!wb[BIT_WATCHDOG_FLAG_STATUS]) begin
                            s_nxt.watchdog_flag_status = 1'b0;
                        end
                    end
                    IDX_REF_CTRL:   s_nxt.ref_ctrl  = wb & 8'h88;
                    IDX_RSVD_CTRL:  s_nxt.rsvd_ctrl = wb & 8'h80;
                    IDX_SO_CTRL:    s_nxt.so_ctrl   = wb & 8'h03;
                    IDX_SO_BEGIN:   s_nxt.so_begin  = wb;
                    IDX_SO_END:     s_nxt.so_end    = wb;
                    IDX_FUSE_SEL:   s_nxt.fuse_sel  = wb;
                    IDX_SI_REV, IDX_FUSE_READ: hit  = 1'b1;
                    default:        hit = 1'b0;
                endcase
            end else begin
                // No low lane: answer as the same write with data would
                hit = s_r.aw_idx inside {IDX_WD_RESTART, IDX_TEST_SEL, IDX_SUM_CYCLES,
                    IDX_WD_FLAG, IDX_REF_CTRL, IDX_RSVD_CTRL, IDX_SI_REV, IDX_SO_CTRL,
                    IDX_SO_BEGIN, IDX_SO_END, IDX_FUSE_SEL, IDX_FUSE_READ};
            end
            s_nxt.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        // Overflow set wins over software clear; external reset clears
        if (watchdog_overflow) begin
            s_nxt.watchdog_flag_status = 1'b1;
        end
        if (!ext_rst_n_s) begin
            s_nxt.watchdog_flag_status = 1'b0;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_fire) begin
            hit = 1'b1;
            unique case (ar_idx)
                IDX_TEST_SEL:   rb = s_r.test_sel;
                IDX_SUM_CYCLES: rb = s_r.sum_cycles;
                IDX_WD_FLAG:    rb = {5'h00, s_r.watchdog_flag_status, 2'b00};
                IDX_REF_CTRL:   rb = s_r.ref_ctrl;
                IDX_RSVD_CTRL:  rb = s_r.rsvd_ctrl;
                IDX_SI_REV:     rb = SI_REVISION;
                IDX_SO_CTRL:    rb = s_r.so_ctrl;
                IDX_SO_BEGIN:   rb = s_r.so_begin;
                IDX_SO_END:     rb = s_r.so_end;
                IDX_FUSE_READ:  rb = fuse_value;
                IDX_WD_RESTART, IDX_FUSE_SEL: rb = 8'h00;
                default:        hit = 1'b0;
            endcase
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = {24'h00_0000, rb};
            s_nxt.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Single state register; the overflow flag survives system reset
    // because it lives in the battery-backed domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '{test_sel: RST_BYTE, sum_cycles: RST_BYTE, watchdog_flag_status: s_r.watchdog_flag_status,
                     ref_ctrl: RST_BYTE, rsvd_ctrl: RST_BYTE, so_ctrl: RST_BYTE,
                     so_begin: RST_BYTE, so_end: RST_BYTE, fuse_sel: RST_BYTE,
                     rst_sync: RST_SYNC_IDLE, default: '0};
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // Assertions
    a_ready_pin_mux: assert property (@(posedge aclk) disable iff (!aresetn)
        rdy_active |-> shared_segment_pin == (serial_ready_strobe ^ s_r.so_ctrl[0]))
        else $error("ready strobe not on segment pin");
    a_ready_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        (rdy_active && s_r.so_ctrl[0]) |-> shared_segment_pin != serial_ready_strobe)
        else $error("ready polarity wrong");
    a_ref_route_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.ref_ctrl[3] |-> !reference_route && reference_off)
        else $error("reference routed while disabled");
    a_ovf_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && watchdog_overflow && ext_rst_n_s) |=> s_r.watchdog_flag_status)
        else $error("overflow flag not set");
    a_ovf_ext_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && !ext_rst_n_s) |=> !s_r.watchdog_flag_status)
        else $error("overflow flag not cleared by reset pin");
    a_fuse_bgb_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && clk_en && ar_idx == IDX_FUSE_READ && s_r.fuse_sel == FUSE_BGB)
        |=> s_axi_rdata[7:0] == $past(bandgap_fuse_b))
        else $error("fuse readout mismatch");
    a_revision_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && clk_en && ar_idx == IDX_SI_REV) |=> s_axi_rdata == 32'h0000_005a)
        else $error("revision read wrong");
    a_wd_restart_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && watchdog_restart_bit) |=> !watchdog_restart_bit)
        else $error("restart not one pulse");
    a_test_sel_rtc: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.test_sel[3:0] == TSEL_RTC |-> test_output_pin == test_sources.rtc_clock)
        else $error("test selector routing wrong");

endmodule // mscr_regs

// [mscr_regs_tb.sv]
/* Self-checking testbench for mscr_regs: register access over AXI4-Lite, pin routing,
 * fuse readout and watchdog flags, with seeded random values among fixed corner cases.
 * Assumes mscr_pkg is compiled first; the bench drives every port itself. */
`timescale 1ns/1ns
module mscr_regs_tb;
    import mscr_pkg::*;
    logic              aclk = 0, aresetn, clk_en, external_reset_n, watchdog_overflow;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              serial_out_enable, serial_ready_strobe, segment_drive, shared_segment_pin;
    mscr_tsrc_t        test_sources;
    logic              test_output_pin, reference_route, reference_off, watchdog_restart_bit;
    logic [2:0]        temperature_fuse;
    logic [7:0]        bandgap_fuse_a, bandgap_fuse_b, block_begin_addr, block_end_addr, d, beg;
    logic [5:0]        sum_cycle_count;
    integer            seed = 32'h9726;
    int                bad_count = 0, check_count = 0, cyc = 0, pulses = 0, p0;
    logic [15:0]       rw_idx [7] = '{IDX_TEST_SEL, IDX_SUM_CYCLES, IDX_REF_CTRL, IDX_RSVD_CTRL,
                                      IDX_SO_CTRL, IDX_SO_BEGIN, IDX_SO_END};
    logic [7:0]        rw_mask [7] = '{8'h0f, 8'h3f, 8'h88, 8'h80, 8'h03, 8'hff, 8'hff};

    mscr_regs dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'b000), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'b000), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .external_reset_n(external_reset_n),
        .watchdog_overflow(watchdog_overflow), .serial_out_enable(serial_out_enable),
        .serial_ready_strobe(serial_ready_strobe), .segment_drive(segment_drive),
        .shared_segment_pin(shared_segment_pin), .test_sources(test_sources),
        .test_output_pin(test_output_pin), .temperature_fuse(temperature_fuse),
        .bandgap_fuse_a(bandgap_fuse_a), .bandgap_fuse_b(bandgap_fuse_b),
        .reference_route(reference_route), .reference_off(reference_off),
        .block_begin_addr(block_begin_addr), .block_end_addr(block_end_addr),
        .sum_cycle_count(sum_cycle_count), .watchdog_restart_bit(watchdog_restart_bit));

    // Clock, hang guard and restart pulse counter
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (watchdog_restart_bit === 1'b1) pulses <= pulses + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Write: both channels offered together, each released once taken
    task automatic wr(input logic [15:0] idx, input logic [31:0] dat, input logic [1:0] er);
        logic a, w, b;
        int   n;
        b = 0;
        n = 0;
        s_axi_awaddr <= ADDR_W'({idx, 2'b00});
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!b && n < 100) begin
            @(negedge aclk);
            a = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            if (b) chk(32'(s_axi_bresp), 32'(er), "write response");
            @(posedge aclk);
            if (a) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
            n++;
        end
        if (!b) chk(32'h0, 32'h1, "write hang");
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] dat, input logic [1:0] er);
        logic a, r;
        int   n;
        r = 0;
        n = 0;
        dat = 'x;
        s_axi_araddr <= ADDR_W'({idx, 2'b00});
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        while (!r && n < 100) begin
            @(negedge aclk);
            a = s_axi_arvalid & s_axi_arready;
            r = s_axi_rvalid;
            if (r) chk(32'(s_axi_rresp), 32'(er), "read response");
            if (r) dat = s_axi_rdata;
            @(posedge aclk);
            if (a) s_axi_arvalid <= 0;
            n++;
        end
        if (!r) chk(32'h0, 32'h1, "read hang");
    endtask

    // Expected test output; analog, reserved and production codes give 0
    function automatic logic test_output_select_exp(input logic [3:0] c, input mscr_tsrc_t s);
        case (c)
            TSEL_RTM: return s.realtime_monitor;
            TSEL_CMPLV: return s.comparator_low_voltage_term;
            TSEL_RXD: return s.optical_rx;
            TSEL_MSYNC: return s.mux_sync;
            TSEL_FAST: return s.fast_clock;
            TSEL_PCLK: return s.processor_clock;
            TSEL_RTC: return s.rtc_clock;
            TSEL_CEBSY: return s.engine_busy;
            TSEL_XFBSY: return s.transfer_busy;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, watchdog_overflow, aresetn} = '0;
        {serial_out_enable, serial_ready_strobe, segment_drive, test_sources} = '0;
        {temperature_fuse, bandgap_fuse_a, bandgap_fuse_b} = '0;
        s_axi_wstrb = 4'hf;
        clk_en = 1;
        external_reset_n = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        // Pin held low past bus reset so the synchronised clear reaches the flag
        repeat (3) @(posedge aclk);
        external_reset_n <= 1;
        repeat (2) @(posedge aclk);
        // Reset values, revision is read-only, unmapped index 2003 answers SLVERR
        foreach (rw_idx[i]) begin
            rd(rw_idx[i], rv, RESP_OKAY);
            chk(rv, 32'h0, "reset value");
        end
        rd(IDX_WD_FLAG, rv, RESP_OKAY);
        chk(rv, 32'h0, "flag after pin reset");
        wr(IDX_SI_REV, 32'h0000_00ff, RESP_OKAY);
        rd(IDX_SI_REV, rv, RESP_OKAY);
        chk(rv, {24'h0, SI_REVISION}, "revision");
        wr(16'h2003, 32'h0000_00ff, RESP_SLVERR);
        rd(16'h2003, rv, RESP_SLVERR);
        // Random read-back through writable masks
        repeat (6) foreach (rw_idx[i]) begin
            d = 8'($random(seed));
            if (rw_idx[i] == IDX_RSVD_CTRL) d = 8'h00;
            if (rw_idx[i] == IDX_SO_BEGIN) d[7] = 1'b0;
            if (rw_idx[i] == IDX_SO_END) d = beg + 8'h01 + {4'h0, d[3:0]};
            beg = (rw_idx[i] == IDX_SO_BEGIN) ? d : beg;
            wr(rw_idx[i], {24'($random(seed)), d}, RESP_OKAY);
            rd(rw_idx[i], rv, RESP_OKAY);
            chk(rv, {24'h0, d & rw_mask[i]}, "read back");
        end
        chk(32'(block_end_addr), 32'(rv[7:0]), "block end");
        rd(IDX_SO_BEGIN, rv, RESP_OKAY);
        chk(32'(block_begin_addr), rv, "block begin");
        rd(IDX_SUM_CYCLES, rv, RESP_OKAY);
        chk(32'(sum_cycle_count), rv, "sum cycles");
        // Low byte strobe clear must leave the register alone
        d = rv[7:0];
        s_axi_wstrb <= 4'he;
        wr(IDX_SUM_CYCLES, ~rv, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(IDX_SUM_CYCLES, rv, RESP_OKAY);
        chk(rv, {24'h0, d}, "strobe ignored");
        // Every selector code against random sources
        for (int c = 0; c < 16; c++) begin
            wr(IDX_TEST_SEL, 32'(c), RESP_OKAY);
            repeat (4) begin
                test_sources <= mscr_tsrc_t'($random(seed));
                @(negedge aclk);
                chk(32'(test_output_pin), 32'(test_output_select_exp(4'(c), test_sources)), "test_output_select");
                @(posedge aclk);
            end
        end
        // Fuse readout per select code, zero for others
        temperature_fuse <= 3'($random(seed));
        bandgap_fuse_a <= 8'($random(seed));
        bandgap_fuse_b <= 8'h00;
        for (int s = 3; s < 8; s++) begin
            wr(IDX_FUSE_SEL, 32'(s), RESP_OKAY);
            rd(IDX_FUSE_READ, rv, RESP_OKAY);
            chk(rv, s == 4 ? 32'(temperature_fuse) : s == 5 ? 32'(bandgap_fuse_a) :
                s == 6 ? 32'(bandgap_fuse_b) : 32'h0, "fuse readout");
        end
        // Reference routing and disable combinations
        for (int i = 0; i < 4; i++) begin
            wr(IDX_REF_CTRL, {24'h0, 1'(i >> 1), 3'b000, 1'(i), 3'b000}, RESP_OKAY);
            @(negedge aclk);
            chk(32'(reference_route), 32'(i == 2), "ref route");
            chk(32'(reference_off), 32'(i & 1), "ref off");
            @(posedge aclk);
        end
        // Segment pin across enable, polarity and pin levels
        for (int c = 0; c < 4; c++) begin
            wr(IDX_SO_CTRL, 32'(c), RESP_OKAY);
            for (int p = 0; p < 8; p++) begin
                {serial_out_enable, serial_ready_strobe, segment_drive} <= 3'(p);
                @(negedge aclk);
                chk(32'(shared_segment_pin), 32'((c > 1 && p > 3) ? ((p >> 1) ^ c) & 1 : p & 1),
                    "segment pin");
                @(posedge aclk);
            end
        end
        // Restart pulse only on bit 7 set
        p0 = pulses;
        wr(IDX_WD_RESTART, 32'h0000_0080, RESP_OKAY);
        wr(IDX_WD_RESTART, 32'h0000_007f, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(pulses - p0), 32'h1, "restart pulses");
        // Overflow flag: set, kept over bus reset, cleared by software and pin
        watchdog_overflow <= 1;
        @(posedge aclk);
        watchdog_overflow <= 0;
        wr(IDX_WD_FLAG, 32'h0000_00ff, RESP_OKAY);
        rd(IDX_WD_FLAG, rv, RESP_OKAY);
        chk(rv, 32'h4, "flag set");
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(IDX_WD_FLAG, rv, RESP_OKAY);
        chk(rv, 32'h4, "flag kept");
        wr(IDX_WD_FLAG, 32'h0000_0000, RESP_OKAY);
        rd(IDX_WD_FLAG, rv, RESP_OKAY);
        chk(rv, 32'h0, "flag cleared");
        watchdog_overflow <= 1;
        @(posedge aclk);
        watchdog_overflow <= 0;
        external_reset_n <= 0;
        repeat (4) @(posedge aclk);
        external_reset_n <= 1;
        @(posedge aclk);
        rd(IDX_WD_FLAG, rv, RESP_OKAY);
        chk(rv, 32'h0, "flag pin clear");
        final_report();
    end
endmodule // mscr_regs_tb
